/* File: level_sync.sv */
// Two-stage synchroniser for the static control pins other than wait select
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire logic clk,
    input wire logic srst,
    trim_sync_if.snk bus
);
    logic [6:0] meta_r;
    logic [6:0] hold_r;
    // Reset values hold every synchronised level low until sampled
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= 7'h00;
            hold_r <= 7'h00;
        end else begin
            meta_r <= bus.raw;
            hold_r <= meta_r;
        end
    end
    assign bus.synced = hold_r;
endmodule
`default_nettype wire

/* File: mode_select_and_self_trim_control.sv */
// Mode decode and self trim sequencer
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Interleave pin high: both channels sample I
// - Interleaved mode ignores Q analog input
// - Interleave pin low: channels convert independently
// - Extended mode: interleave from bit 7
// - Wait select picks long or short delay
// - Wait select works in both modes
// - Trigger low then high starts trim
// - Trigger high at power-on withholds auto trim
// - Extended mode ORs trigger with bit 15
// - Active output high only while trimming
// - Sleep pin powers channel down, wakes later
// - Extended mode ORs sleep with bits 11/10
// - Pattern pin high outputs test pattern
// - Extended mode pattern only from bit 12
// - Width pin high 1:1, low 1:2
// - Enable low selects extended settings mode
// - Enable high holds registers at defaults
module mode_select_and_self_trim_control #(
    parameter int WAIT_SHORT = trim_ctl_pkg::WAIT_SHORT_CYC,
    parameter int WAIT_LONG = trim_ctl_pkg::WAIT_LONG_CYC,
    parameter int RUN_LEN = trim_ctl_pkg::TRIM_RUN_CYC,
    parameter int WAKE_LEN = trim_ctl_pkg::WAKE_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic interleave_select,
    input wire logic self_trim_wait_select,
    input wire logic self_trim_request,
    input wire logic i_path_sleep,
    input wire logic q_path_sleep,
    input wire logic pattern_output_select,
    input wire logic output_width_select,
    input wire logic extended_settings_enable_n,
    input wire logic [15:0] ctrl_reg_wdata,
    input wire logic ctrl_reg_we,
    output logic [15:0] ctrl_reg_rdata,
    output logic extended_settings_mode,
    output logic interleaved,
    output logic q_input_used,
    output logic i_path_down,
    output logic q_path_down,
    output logic i_path_ready,
    output logic q_path_ready,
    output logic pattern_active,
    output logic width_one_to_one,
    output logic self_trim_active
);
    trim_sync_if sif ();
    logic [15:0] ctrl_r;
    logic [16:0] wait_cnt_r;
    logic [16:0] run_cnt_r;
    logic [15:0] pulse_cnt_r;
    logic [15:0] i_wake_r;
    logic [15:0] q_wake_r;
    logic trig_prev_r;
    logic trig;
    logic ext;
    logic i_dn;
    logic q_dn;
    trim_ctl_pkg::trim_state_t state_r;
    logic auto_done_r;

    assign sif.raw = {extended_settings_enable_n, output_width_select,
        pattern_output_select, q_path_sleep, i_path_sleep,
        self_trim_request, interleave_select};

    level_sync u_sync (
        .clk(clk),
        .srst(srst),
        .bus(sif)
    );

    // Pin low enables extended mode
    assign ext = ~sif.synced[6];

    // Control word cleared whenever pins are in charge
    always_ff @(posedge clk) begin
        if (srst || !ext) begin
            ctrl_r <= trim_ctl_pkg::CTRL_RESET;
        end else if (ctrl_reg_we) begin
            ctrl_r <= ctrl_reg_wdata;
        end
    end

    assign trig = sif.synced[1] |
        (ext & ctrl_r[trim_ctl_pkg::BIT_TRIM_REQ]);
    assign i_dn = sif.synced[2] |
        (ext & ctrl_r[trim_ctl_pkg::BIT_I_SLEEP]);
    assign q_dn = sif.synced[3] |
        (ext & ctrl_r[trim_ctl_pkg::BIT_Q_SLEEP]);

    // Decoded modes registered for glitch-free outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            interleaved <= 1'b0;
            q_input_used <= 1'b1;
            pattern_active <= 1'b0;
            width_one_to_one <= 1'b0;
            extended_settings_mode <= 1'b0;
            i_path_down <= 1'b0;
            q_path_down <= 1'b0;
        end else begin
            extended_settings_mode <= ext;
            interleaved <= ext ? ctrl_r[trim_ctl_pkg::BIT_INTERLEAVE]
                : sif.synced[0];
            q_input_used <= ~(ext ? ctrl_r[trim_ctl_pkg::BIT_INTERLEAVE]
                : sif.synced[0]);
            pattern_active <= ext ? ctrl_r[trim_ctl_pkg::BIT_PATTERN]
                : sif.synced[4];
            width_one_to_one <= sif.synced[5];
            i_path_down <= i_dn;
            q_path_down <= q_dn;
        end
    end

    // Wake delay after sleep released
    always_ff @(posedge clk) begin
        if (srst) begin
            i_wake_r <= 16'h0000;
            q_wake_r <= 16'h0000;
        end else begin
            i_wake_r <= i_dn ? 16'h0000 : (i_wake_r < 16'(WAKE_LEN)
                ? i_wake_r + 16'h0001 : i_wake_r);
            q_wake_r <= q_dn ? 16'h0000 : (q_wake_r < 16'(WAKE_LEN)
                ? q_wake_r + 16'h0001 : q_wake_r);
        end
    end
    assign i_path_ready = i_wake_r == 16'(WAKE_LEN);
    assign q_path_ready = q_wake_r == 16'(WAKE_LEN);

    // Trigger phase timer: counts low then high time
    always_ff @(posedge clk) begin
        if (srst) begin
            trig_prev_r <= 1'b0;
            pulse_cnt_r <= 16'h0000;
        end else begin
            trig_prev_r <= trig;
            if (trig != trig_prev_r) begin
                pulse_cnt_r <= 16'h0000;
            end else if (pulse_cnt_r != 16'hffff) begin
                pulse_cnt_r <= pulse_cnt_r + 16'h0001;
            end
        end
    end

    // Sequencer; wait select used in both modes
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= trim_ctl_pkg::ST_WAIT_POWER;
            wait_cnt_r <= 17'h0_0000;
            run_cnt_r <= 17'h0_0000;
            auto_done_r <= 1'b0;
        end else begin
            case (state_r)
                trim_ctl_pkg::ST_WAIT_POWER: begin
                    wait_cnt_r <= wait_cnt_r + 17'h0_0001;
                    if (trig && wait_cnt_r == 17'h0_0003) begin
                        // Trigger high once sync settles: inhibit
                        state_r <= trim_ctl_pkg::ST_ARM_LOW;
                    end else if (wait_cnt_r >= (sif.synced[5] ? 17'h0_0000
                        : 17'h0_0000) + (self_trim_wait_select
                        ? 17'(WAIT_LONG) : 17'(WAIT_SHORT))) begin
                        state_r <= trim_ctl_pkg::ST_RUN;
                        run_cnt_r <= 17'h0_0000;
                        auto_done_r <= 1'b1;
                    end
                end
                trim_ctl_pkg::ST_ARM_LOW: begin
                    if (!trig && pulse_cnt_r >=
                        16'(trim_ctl_pkg::TRIM_L_CYC - 1)) begin
                        state_r <= trim_ctl_pkg::ST_IDLE;
                    end
                end
                trim_ctl_pkg::ST_IDLE: begin
                    if (trig && pulse_cnt_r ==
                        16'(trim_ctl_pkg::TRIM_H_CYC - 1)) begin
                        state_r <= trim_ctl_pkg::ST_RUN;
                        run_cnt_r <= 17'h0_0000;
                    end else if (trig && pulse_cnt_r == 16'h0000 &&
                        !trig_prev_r) begin
                        state_r <= trim_ctl_pkg::ST_IDLE;
                    end
                end
                trim_ctl_pkg::ST_RUN: begin
                    run_cnt_r <= run_cnt_r + 17'h0_0001;
                    if (run_cnt_r == 17'(RUN_LEN - 1)) begin
                        state_r <= trim_ctl_pkg::ST_ARM_LOW;
                    end
                end
                default: state_r <= trim_ctl_pkg::ST_WAIT_POWER;
            endcase
        end
    end

    assign self_trim_active = state_r == trim_ctl_pkg::ST_RUN;
    assign ctrl_reg_rdata = ctrl_r;

    AST_PAT_EXT: assert property (@(posedge clk) disable iff (srst)
        ext |=> pattern_active == $past(ctrl_r[12]))
        else $error("pattern not from register in extended mode");
    AST_INTL: assert property (@(posedge clk) disable iff (srst)
        !ext |=> interleaved == $past(sif.synced[0]))
        else $error("interleave does not follow pin");
    AST_QIGN: assert property (@(posedge clk) disable iff (srst)
        interleaved |-> !q_input_used)
        else $error("q input used while interleaved");
    AST_WIDTH: assert property (@(posedge clk) disable iff (srst)
        ##1 width_one_to_one == $past(sif.synced[5]))
        else $error("width select wrong");
    AST_DEFAULT: assert property (@(posedge clk) disable iff (srst)
        !ext |=> ctrl_r == 16'h0000)
        else $error("register not at default");
    AST_RUN_LEN: assert property (@(posedge clk) disable iff (srst)
        $rose(self_trim_active) |-> self_trim_active [*8])
        else $error("trim active dropped early");
    AST_SLEEP: assert property (@(posedge clk) disable iff (srst)
        i_dn |=> i_path_down && !i_path_ready)
        else $error("i sleep not applied");
    AST_QSLEEP: assert property (@(posedge clk) disable iff (srst)
        (ext && ctrl_r[10]) |=> q_path_down)
        else $error("q sleep bit ignored");
endmodule
`default_nettype wire

/* File: mode_select_and_self_trim_control_tb_top.sv */
// Self-checking bench for mode decode and self trim
`timescale 1ns/1ps
`default_nettype none
module mode_select_and_self_trim_control_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic look = 1'b0;
    logic [7:0] p;
    logic [15:0] r;
    wire logic [7:0] pins;
    wire logic [15:0] wdata;
    wire logic we;
    wire logic [15:0] rdata;
    wire logic [9:0] obs;
    logic [9:0] exp_q[$];
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    integer seed;
    initial forever #12.5 clk = ~clk;
    pin_ctl_model m (.clk(clk), .pins(pins), .wdata(wdata), .we(we));
    mode_select_and_self_trim_control #(.WAIT_SHORT(16), .WAIT_LONG(32),
        .RUN_LEN(16), .WAKE_LEN(4)) uut (
        .clk(clk), .srst(srst), .interleave_select(pins[6]),
        .self_trim_wait_select(pins[4]), .self_trim_request(pins[5]),
        .i_path_sleep(pins[3]), .q_path_sleep(pins[2]),
        .pattern_output_select(pins[1]), .output_width_select(pins[0]),
        .extended_settings_enable_n(pins[7]), .ctrl_reg_wdata(wdata),
        .ctrl_reg_we(we), .ctrl_reg_rdata(rdata),
        .extended_settings_mode(obs[9]), .interleaved(obs[8]),
        .q_input_used(obs[7]), .i_path_down(obs[6]), .q_path_down(obs[5]),
        .pattern_active(obs[4]), .width_one_to_one(obs[3]),
        .self_trim_active(obs[2]), .i_path_ready(obs[1]),
        .q_path_ready(obs[0]));
    task automatic check(string nm, logic [15:0] seen, logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // Expected levels from pins and register, worked out independently
    function automatic logic [9:0] expect_of(logic [7:0] q, logic [15:0] c);
        logic x, il, id, qd;
        x = ~q[7];
        il = x ? c[7] : q[6];
        id = q[3] | (x & c[11]);
        qd = q[2] | (x & c[10]);
        return {x, il, ~il, id, qd, x ? c[12] : q[1], q[0], 1'b0, ~id, ~qd};
    endfunction
    task automatic sample(logic [7:0] q, logic [15:0] c);
        exp_q.push_back(expect_of(q, c));
        #1 look = 1'b1;
        #1 look = 1'b0;
    endtask
    always @(posedge look)
        check("decode", {6'h00, obs}, {6'h00, exp_q.pop_front()});
    task automatic run_trim(int lo);
        n = 0;
        while (obs[2] !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check("trim_start", 16'(n >= lo && n < 300), 16'h0001);
        n = 0;
        while (obs[2] === 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check("trim_len", 16'(n), 16'h0010);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Generous ceiling; the whole sequence needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        seed = 32'hdf4b;
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        run_trim(16);
        $display("power-up trim done");
        repeat (12) begin
            p = 8'h80 | (8'($random(seed)) & 8'h4f);
            m.set_pins(p);
            repeat (12) @(posedge clk);
            sample(p, 16'h0000);
        end
        m.trim_pulse();
        run_trim(0);
        $display("pin decode and command trim done");
        m.set_pins(8'h03);
        repeat (4) @(posedge clk);
        repeat (8) begin
            r = 16'($random(seed)) & 16'h1c80;
            m.wr(r);
            repeat (4) @(posedge clk);
            sample(8'h03, r);
            check("rdata", rdata, r);
        end
        m.wr(16'h8000);
        run_trim(0);
        m.wr(16'h0000);
        m.set_pins(8'h83);
        repeat (6) @(posedge clk);
        m.wr(16'h1c80);
        repeat (4) @(posedge clk);
        check("rdata_held", rdata, 16'h0000);
        sample(8'h83, 16'h0000);
        $display("extended mode done");
        m.set_pins(8'hb0);
        #1 srst = 1'b1;
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge clk);
            if (obs[2] !== 1'b0)
                n++;
        end
        check("trim_withheld", 16'(n), 16'h0000);
        m.trim_pulse();
        run_trim(0);
        $display("withheld power-up trim done");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: pin_ctl_model.sv */
// Board controller model driving the static control pins
`timescale 1ns/1ps
`default_nettype none
module pin_ctl_model (
    input wire logic clk,
    output logic [7:0] pins,
    output logic [15:0] wdata,
    output logic we
);
    initial begin
        pins = 8'h80;
        wdata = 16'h0000;
        we = 1'b0;
    end
    // Pins move just after the edge, never on it
    task automatic set_pins(input logic [7:0] v);
        @(posedge clk) #1 pins = v;
    endtask
    // Five cycles low, above the four the sequencer wants, then left high
    task automatic trim_pulse();
        @(posedge clk) #1 pins[5] = 1'b0;
        repeat (5) @(posedge clk);
        #1 pins[5] = 1'b1;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clk) #1 wdata = d;
        we = 1'b1;
        @(posedge clk) #1 we = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: trim_ctl_pkg.sv */
// Package: constants for mode select and self trim control
package trim_ctl_pkg;
    localparam int CTRL_W = 16;
    localparam int BIT_INTERLEAVE = 7;
    localparam int BIT_I_SLEEP = 11;
    localparam int BIT_Q_SLEEP = 10;
    localparam int BIT_PATTERN = 12;
    localparam int BIT_TRIM_REQ = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int CLK_MHZ = 40;
    localparam int TRIM_L_NS = 100;
    localparam int TRIM_H_NS = 100;
    localparam int TRIM_L_CYC = (TRIM_L_NS * CLK_MHZ + 999) / 1000;
    localparam int TRIM_H_CYC = (TRIM_H_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_SHORT_CYC = 4096;
    localparam int WAIT_LONG_CYC = 65536;
    localparam int TRIM_RUN_CYC = 8192;
    localparam int WAKE_CYC = 64;
    typedef enum logic [2:0] {
        ST_WAIT_POWER = 3'b000,
        ST_ARM_LOW = 3'b001,
        ST_IDLE = 3'b010,
        ST_RUN = 3'b011
    } trim_state_t;
endpackage

/* File: trim_sync_if.sv */
// Interface: synchronised static control levels
`timescale 1ns/1ps
`default_nettype none
interface trim_sync_if;
    logic [6:0] raw;
    logic [6:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface
`default_nettype wire
